// ---- scis_irq_status.sv ----
/*
 serial channel interrupt status: pin config, two clear-on-read status
 registers, masks, priority rotation, cascade acknowledge and irq pin stage.
 assumes classic wishbone master on core_clk, event pulses from the channel
 logic on core_clk, and cascade, ack and carrier pins from outside.
*/
// Added by the designer: the Wishbone register port.
// Behaviour
// - pin config seen at eight channel addresses
// - masked bits hidden unless shown setting set
// - scope 0 rotates all eight channels
// - scope 1 keeps one channel fixed highest
// - slave cascade acks on address match
// - daisy chain uses pin1 enable in
// - chain pin0 low while irq active
// - style field selects open drain or push-pull
// - receive status cleared by read
// - msg end, pool full cleared at vector
// - masked shown bits never raise irq
// - set msg end on message end event
// - set frame start on frame start event
// - remote change only in auto mode
// - protocol error only in auto mode
// - dpll unlock flags and aborts receive
// - carrier change on either edge
// - frame lost on discarded frame
// - pool full only in interrupt mode
// - link status cleared by read, tx pool at vector
// - poll end set in loop mode
// - on loop set after poll end, repeat on
// - overrun set outside loop mode
// - masks reset to all ones, one blocks
`timescale 1ns/1ps
`include "scis_defs.svh"
module scis_irq_status #(
    parameter int CHANNELS = 8
) (
    input wire logic core_clk,
    input wire logic arst_n,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [10:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // channel events, one-cycle pulses except the remote ready and dpll lock levels
    input wire logic evMsgEnd,
    input wire logic evFrameStart,
    input wire logic evRemoteReady,
    input wire logic evProtoErr,
    input wire logic dpllLocked,
    input wire logic evFrameLost,
    input wire logic evPoolFull,
    input wire logic evPollEnd,
    input wire logic evOnLoop,
    input wire logic evOverrun,
    input wire logic evTxPool,
    // operating modes
    input wire logic autoMode,
    input wire logic irqMode,
    input wire logic loopMode,
    input wire logic dpllInUse,
    input wire logic txFromDpll,
    // pins
    input wire logic carrierSensePin,
    input wire logic irqAckCycle,
    input wire logic [2:0] chainPinIn,
    output logic chainPin0Out,
    output logic chainPin0Oe,
    output logic irqPinOut,
    output logic irqPinOe,
    // channel control outputs
    output logic rxAbort,
    output logic txHalt,
    output logic loopRepeat,
    output logic [2:0] highChannel
);
    // register file
    logic [7:0] pinCfg;
    logic [7:0] statRx;
    logic [7:0] statLink;
    logic [7:0] maskRx;
    logic [7:0] maskLink;
    logic [7:0] ctrl;
    // ctrl bit 0 enables rotation, bits 3:1 fixed channel for scope 1
    logic rotEnable;
    assign rotEnable = ctrl[0];

    // synchronised pins: carrier, ack, chain inputs
    logic [4:0] pinSync;
    scis_sync #(.WIDTH(5)) syncPins (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .pinIn({carrierSensePin, irqAckCycle, chainPinIn}),
        .pinSync(pinSync)
    );
    logic carrierNow;
    logic ackNow;
    logic [2:0] chainNow;
    assign carrierNow = pinSync[4];
    assign ackNow = pinSync[3];
    assign chainNow = pinSync[2:0];

    // wishbone decode
    logic [8:0] idx;
    logic acc;
    logic isCfg;
    logic rdRx;
    logic rdLink;
    assign idx = wb_adr_i[10:2];
    assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // eight mirrors of the config word
    assign isCfg = {3'h0, idx[5:0]} == `SCIS_IDX_PIN_CFG;
    assign rdRx = acc && !wb_we_i && idx == `SCIS_IDX_STAT_RX;
    assign rdLink = acc && !wb_we_i && idx == `SCIS_IDX_STAT_LINK;
    logic wrLane;
    assign wrLane = acc && wb_we_i && wb_sel_i[0];

    // single-cycle ack, dropped the cycle after
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= acc;
    end

    // config, masks and control writes
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pinCfg <= `SCIS_PIN_CFG_RST;
            maskRx <= `SCIS_MASK_RST;
            maskLink <= `SCIS_MASK_RST;
            ctrl <= 8'h00;
        end
        else if (wrLane)
        begin
            if (isCfg)
                pinCfg <= wb_dat_i[7:0];
            if (idx == `SCIS_IDX_MASK_RX)
                maskRx <= wb_dat_i[7:0];
            if (idx == `SCIS_IDX_MASK_LINK)
                maskLink <= wb_dat_i[7:0];
            if (idx == `SCIS_IDX_CTRL)
                ctrl <= wb_dat_i[7:0];
        end
    end

    // unmasked pending sources
    logic [7:0] liveRx;
    logic [7:0] liveLink;
    logic anyLive;
    // mask gates irq regardless of shown setting
    assign liveRx = statRx & ~maskRx;
    assign liveLink = statLink & ~maskLink;
    assign anyLive = |{liveRx, liveLink};

    // shown view of the status registers
    logic [7:0] viewRx;
    logic [7:0] viewLink;
    assign viewRx = pinCfg[`SCIS_CFG_SHOWN] ? statRx : liveRx;
    assign viewLink = pinCfg[`SCIS_CFG_SHOWN] ? statLink : liveLink;

    // read data mux, unmapped reads as zero
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            wb_dat_o <= 32'h0000_0000;
        else if (acc && !wb_we_i)
        begin
            if (isCfg)
                wb_dat_o <= {24'h000000, pinCfg};
            else if (idx == `SCIS_IDX_STAT_RX)
                wb_dat_o <= {24'h000000, viewRx};
            else if (idx == `SCIS_IDX_STAT_LINK)
                wb_dat_o <= {24'h000000, viewLink};
            else if (idx == `SCIS_IDX_MASK_RX)
                wb_dat_o <= {24'h000000, maskRx};
            else if (idx == `SCIS_IDX_MASK_LINK)
                wb_dat_o <= {24'h000000, maskLink};
            else if (idx == `SCIS_IDX_CTRL)
                wb_dat_o <= {24'h000000, ctrl};
            else if (idx == `SCIS_IDX_SUMMARY)
                wb_dat_o <= {28'h0000000, anyLive, highChannel};
            else
                wb_dat_o <= 32'h0000_0000;
        end
    end

    // acknowledge handling
    scis_pkg::scis_ack_t ackState;
    logic ackPrev;
    logic ackRise;
    logic irqActive;
    logic ackAccept;
    logic vectorOut;
    assign ackRise = ackNow && !ackPrev;
    // daisy chain needs enable input high
    assign ackAccept = irqActive && ackRise &&
        (pinCfg[`SCIS_CFG_CASC] ? chainNow[1]
                                : chainNow == pinCfg[`SCIS_CFG_SLA_HI:`SCIS_CFG_SLA_LO]);
    assign vectorOut = ackState == scis_pkg::ACK_VECTOR;

    // irq active level, one cycle behind anyLive
    // irq follows unmasked pending bits
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            irqActive <= 1'b0;
        else
            irqActive <= anyLive;
    end

    // ack sequencer: vector phase lasts one cycle
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ackState <= scis_pkg::ACK_IDLE;
            ackPrev <= 1'b0;
        end
        else
        begin
            ackPrev <= ackNow;
            case (ackState)
                scis_pkg::ACK_IDLE:
                    if (ackAccept)
                        ackState <= scis_pkg::ACK_VECTOR;
                scis_pkg::ACK_VECTOR:
                    ackState <= scis_pkg::ACK_DONE;
                scis_pkg::ACK_DONE:
                    if (!ackNow)
                        ackState <= scis_pkg::ACK_IDLE;
                default:
                    ackState <= scis_pkg::ACK_IDLE;
            endcase
        end
    end

    // carrier edge detect on synced level
    logic carrierPrev;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            carrierPrev <= 1'b0;
        else
            carrierPrev <= carrierNow;
    end

    // dpll lock edge and remote ready memory
    logic lockPrev;
    logic remoteReady;
    logic unlockEv;
    logic remoteEv;
    assign unlockEv = dpllInUse && lockPrev && !dpllLocked;
    assign remoteEv = autoMode && evRemoteReady != remoteReady;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lockPrev <= 1'b1;
            remoteReady <= 1'b1;
        end
        else
        begin
            lockPrev <= dpllLocked;
            if (autoMode)
                remoteReady <= evRemoteReady;
        end
    end

    // receive event set vector
    logic [7:0] setRx;
    always_comb
    begin
        setRx = 8'h00;
        setRx[`SCIS_RX_MSG_END] = evMsgEnd;
        setRx[`SCIS_RX_FRAME_START] = evFrameStart;
        setRx[`SCIS_RX_REMOTE] = remoteEv;
        setRx[`SCIS_RX_PROTO] = autoMode && evProtoErr;
        setRx[`SCIS_RX_DPLL] = unlockEv;
        setRx[`SCIS_RX_CARRIER] = carrierNow != carrierPrev;
        setRx[`SCIS_RX_LOST] = evFrameLost;
        setRx[`SCIS_RX_POOL] = irqMode && evPoolFull;
    end

    // link event set vector, unused middle bits stay clear
    logic [7:0] setLink;
    always_comb
    begin
        setLink = 8'h00;
        setLink[`SCIS_LK_POLL_END] = loopMode && evPollEnd;
        // on loop / overrun share the bit
        setLink[`SCIS_LK_ON_LOOP] = loopMode ? evOnLoop : evOverrun;
        setLink[`SCIS_LK_TX_POOL] = evTxPool;
    end

    // clears by read and by vector output; set wins
    logic [7:0] clrRx;
    logic [7:0] clrLink;
    always_comb
    begin
        clrRx = 8'h00;
        clrLink = 8'h00;
        if (rdRx)
            clrRx = 8'hFF;
        // vector clears msg end, pool full
        if (vectorOut)
        begin
            clrRx[`SCIS_RX_MSG_END] = 1'b1;
            clrRx[`SCIS_RX_POOL] = 1'b1;
        end
        // link clear on read and tx pool at vector
        if (rdLink)
            clrLink = 8'hFF;
        if (vectorOut)
            clrLink[`SCIS_LK_TX_POOL] = 1'b1;
    end

    // sticky status registers
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            statRx <= 8'h00;
            statLink <= 8'h00;
        end
        else
        begin
            statRx <= (statRx & ~clrRx) | setRx;
            statLink <= (statLink & ~clrLink) | setLink;
        end
    end

    // channel control: abort, halt, repeat
    logic onLoop;
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rxAbort <= 1'b0;
            txHalt <= 1'b0;
            onLoop <= 1'b0;
            loopRepeat <= 1'b0;
        end
        else
        begin
            rxAbort <= dpllInUse && !dpllLocked;
            txHalt <= dpllInUse && txFromDpll && !dpllLocked;
            if (!loopMode)
                onLoop <= 1'b0;
            else if (evOnLoop)
                onLoop <= 1'b1;
            loopRepeat <= onLoop && loopMode;
        end
    end

    // priority rotation on each accepted ack
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            highChannel <= 3'h0;
        else if (vectorOut && rotEnable)
        begin
            // all eight rotate, serviced goes lowest
            if (!pinCfg[`SCIS_CFG_SCOPE])
                highChannel <= highChannel + 3'h1;
            else
                highChannel <= ctrl[3:1];
        end
    end

    // pin stage: chain enable and irq style
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            chainPin0Out <= 1'b1;
            chainPin0Oe <= 1'b0;
            irqPinOut <= 1'b0;
            irqPinOe <= 1'b0;
        end
        else
        begin
            chainPin0Oe <= pinCfg[`SCIS_CFG_CASC];
            chainPin0Out <= !(anyLive || irqActive) && chainNow[1];
            // style: x0 open drain, 01 low, 11 high
            if (!pinCfg[`SCIS_CFG_STYLE_LO])
            begin
                irqPinOut <= 1'b0;
                irqPinOe <= anyLive;
            end
            else
            begin
                irqPinOut <= pinCfg[`SCIS_CFG_STYLE_HI] ? anyLive : !anyLive;
                irqPinOe <= 1'b1;
            end
        end
    end

    // assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence rxRead_s;
        rdRx && setRx == 8'h00;
    endsequence
    rx_read_clear_a: assert property (rxRead_s |=> statRx == 8'h00)
        else $error("receive status not cleared by read");
    link_read_clear_a: assert property (rdLink && setLink == 8'h00 |=> statLink == 8'h00)
        else $error("link status not cleared by read");
    mask_reset_a: assert property ($rose(arst_n) |-> maskRx == 8'hFF && maskLink == 8'hFF)
        else $error("masks not all ones after reset");
    irq_follow_a: assert property (anyLive |=> irqActive)
        else $error("irq not raised for unmasked bit");
    masked_quiet_a: assert property ((statRx & ~maskRx) == 8'h00 && (statLink & ~maskLink) == 8'h00
        && !pinCfg[`SCIS_CFG_STYLE_LO] |=> !irqPinOe)
        else $error("irq raised with only masked bits");
    carrier_edge_a: assert property (carrierNow != carrierPrev |=> statRx[`SCIS_RX_CARRIER])
        else $error("carrier change not flagged");
    vector_clear_a: assert property (vectorOut && !evMsgEnd |=> !statRx[`SCIS_RX_MSG_END])
        else $error("msg end not cleared at vector");
    chain_block_a: assert property (irqActive |=> !chainPin0Out)
        else $error("chain enable not low during irq");
    push_high_a: assert property (pinCfg[1:0] == 2'b11 && anyLive |=> irqPinOut && irqPinOe)
        else $error("push-pull high style wrong");
    rotate_all_a: assert property (vectorOut && rotEnable && !pinCfg[6]
        |=> highChannel == $past(highChannel) + 3'h1)
        else $error("rotation step wrong");
    pool_mode_a: assert property (!irqMode && !rdRx && !statRx[0] |=> !statRx[`SCIS_RX_POOL])
        else $error("pool full outside interrupt mode");
endmodule : scis_irq_status

// ---- scis_defs.svh ----
/*
 constants for the serial channel interrupt status block: register offsets,
 field positions, reset values. assumes it is included by the interrupt status module.
*/
`ifndef SCIS_DEFS_SVH
`define SCIS_DEFS_SVH
// word indices of the registers (byte address = 4 * index)
`define SCIS_IDX_PIN_CFG 9'h039
`define SCIS_IDX_STAT_RX 9'h03A
`define SCIS_IDX_STAT_LINK 9'h03B
`define SCIS_IDX_MASK_RX 9'h03C
`define SCIS_IDX_MASK_LINK 9'h03D
`define SCIS_IDX_CTRL 9'h03E
`define SCIS_IDX_SUMMARY 9'h03F
// channel-window stride of the pin config register
`define SCIS_CHAN_STRIDE 9'h040
// reset values
`define SCIS_PIN_CFG_RST 8'h00
`define SCIS_MASK_RST 8'hFF
// pin config fields
`define SCIS_CFG_SHOWN 7
`define SCIS_CFG_SCOPE 6
`define SCIS_CFG_SLA_HI 5
`define SCIS_CFG_SLA_LO 3
`define SCIS_CFG_CASC 2
`define SCIS_CFG_STYLE_HI 1
`define SCIS_CFG_STYLE_LO 0
// receive status bits
`define SCIS_RX_MSG_END 7
`define SCIS_RX_FRAME_START 6
`define SCIS_RX_REMOTE 5
`define SCIS_RX_PROTO 4
`define SCIS_RX_DPLL 3
`define SCIS_RX_CARRIER 2
`define SCIS_RX_LOST 1
`define SCIS_RX_POOL 0
// link status bits
`define SCIS_LK_POLL_END 7
`define SCIS_LK_ON_LOOP 6
`define SCIS_LK_TX_POOL 0
// message threshold in bytes
`define SCIS_POOL_BYTES 32
`endif

// ---- scis_pkg.sv ----
/*
 types for the serial channel interrupt status block.
 assumes nothing beyond a systemverilog compiler.
*/
package scis_pkg;
    // acknowledge cycle phases
    typedef enum logic [1:0] {ACK_IDLE, ACK_VECTOR, ACK_DONE} scis_ack_t;
endpackage : scis_pkg

// ---- scis_sync.sv ----
/*
 two-flop synchroniser for a vector of pins.
 assumes the pins are asynchronous to core_clk.
*/
`timescale 1ns/1ps
module scis_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] pinIn,
    output logic [WIDTH-1:0] pinSync
);
    // first stage, read only by the second
    logic [WIDTH-1:0] stage1;

    // plain double register
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stage1 <= '0;
            pinSync <= '0;
        end
        else
        begin
            stage1 <= pinIn;
            pinSync <= stage1;
        end
    end
endmodule : scis_sync

// ---- scis_ack_host.sv ----
/*
 host side acknowledge model: runs one acknowledge cycle on request.
 assumes requests come on core_clk, one at a time, never while busy.
*/
`timescale 1ns/1ps
module scis_ack_host (
    input wire logic core_clk,
    input wire logic go,
    input wire logic [2:0] chainAddr,
    output logic irqAckCycle,
    output logic [2:0] chainPins,
    output logic busy
);
    int cnt; // cycles into the acknowledge
    // idle pins sit low, nothing acknowledged
    initial
    begin
        irqAckCycle = 1'b0;
        chainPins = 3'h0;
        busy = 1'b0;
        cnt = 0;
    end
    // address or enable in held around the whole cycle
    // pins stand two cycles before the strobe and three after, past the sync delay
    always @(posedge core_clk)
    begin
        if (go && !busy)
        begin
            busy <= 1'b1;
            chainPins <= chainAddr;
            cnt <= 0;
        end
        else if (busy)
        begin
            cnt <= cnt + 1;
            if (cnt == 1)
                irqAckCycle <= 1'b1;
            if (cnt == 8)
                irqAckCycle <= 1'b0;
            // released pins flip, so a stale match is never seen
            if (cnt == 11)
            begin
                chainPins <= ~chainPins;
                busy <= 1'b0;
            end
        end
    end
endmodule : scis_ack_host

// ---- serial_channel_irq_status_bench.sv ----
/*
 self-checking bench: wishbone master tasks, event pulses, ack model.
 assumes a single 200 MHz clock and the hand-over latencies.
*/
`timescale 1ns/1ps
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH t=%0t %s", $time, m); end end
module serial_channel_irq_status_bench;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
    logic [10:0] adr = 11'h000;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack;
    logic [8:0] ev = 9'h000; // one bit per event pulse
    logic remoteRdy = 1'b0, locked = 1'b1, autoM = 1'b0, irqM = 1'b0;
    logic loopM = 1'b0, dpllUse = 1'b0, txDpll = 1'b0, carrier = 1'b0;
    logic go = 1'b0;
    logic [2:0] ackAddr = 3'h0;
    logic hostAck, hostBusy, ch0Out, ch0Oe, irqOut, irqOe, rxAbort, txHalt, loopRep;
    logic [2:0] hostPins, highCh, chainIn;
    int err_count = 0, num_checks = 0, cycles = 0;
    // chain pin 0 is shared: device drives it when enabled
    assign chainIn = {hostPins[2:1], ch0Oe ? ch0Out : hostPins[0]};
    // 5 ns clock
    initial
    begin
        forever #2.5 core_clk = ~core_clk;
    end
    scis_irq_status u_scis_irq_status (.core_clk(core_clk), .arst_n(arst_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .evMsgEnd(ev[0]), .evFrameStart(ev[1]), .evRemoteReady(remoteRdy),
        .evProtoErr(ev[2]), .dpllLocked(locked), .evFrameLost(ev[3]),
        .evPoolFull(ev[4]), .evPollEnd(ev[5]), .evOnLoop(ev[6]),
        .evOverrun(ev[7]), .evTxPool(ev[8]), .autoMode(autoM), .irqMode(irqM),
        .loopMode(loopM), .dpllInUse(dpllUse), .txFromDpll(txDpll),
        .carrierSensePin(carrier), .irqAckCycle(hostAck), .chainPinIn(chainIn),
        .chainPin0Out(ch0Out), .chainPin0Oe(ch0Oe), .irqPinOut(irqOut),
        .irqPinOe(irqOe), .rxAbort(rxAbort), .txHalt(txHalt), .loopRepeat(loopRep),
        .highChannel(highCh));
    scis_ack_host u_scis_ack_host (.core_clk(core_clk), .go(go), .chainAddr(ackAddr),
        .irqAckCycle(hostAck), .chainPins(hostPins), .busy(hostBusy));
    // verdict, the only exit
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    // hang guard, well above the few hundred cycles needed
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            finish_test();
        end
    end
    // one classic cycle; held until ack is sampled high
    task wbXfer(input logic w, input logic [8:0] idx, input logic [7:0] d,
                output logic [7:0] r);
        @(posedge core_clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, d};
        do @(posedge core_clk); while (ack !== 1'b1);
        r = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wbXfer
    task wrReg(input logic [8:0] idx, input logic [7:0] d);
        logic [7:0] r;
        wbXfer(1'b1, idx, d, r);
    endtask : wrReg
    task rdChk(input logic [8:0] idx, input logic [7:0] e);
        logic [7:0] r;
        wbXfer(1'b0, idx, 8'h00, r);
        `CHK(r, e, "register read")
    endtask : rdChk
    task pulse(input int b);
        @(posedge core_clk);
        ev[b] <= 1'b1;
        @(posedge core_clk);
        ev <= 9'h000;
    endtask : pulse
    task waitN(input int n);
        repeat (n) @(posedge core_clk);
    endtask : waitN
    // one acknowledge through the host model
    task ackCycle(input logic [2:0] a);
        @(posedge core_clk);
        go <= 1'b1;
        ackAddr <= a;
        @(posedge core_clk);
        go <= 1'b0;
        do @(posedge core_clk); while (hostBusy);
        waitN(2);
    endtask : ackCycle
    // reset values, mirror windows, unmapped place
    task tRegs;
        rdChk(9'h039, 8'h00);
        rdChk(9'h03A, 8'h00);
        rdChk(9'h03C, 8'hFF);
        rdChk(9'h03D, 8'hFF);
        rdChk(9'h010, 8'h00);
        wrReg(9'h179, 8'h41);
        for (int n = 0; n < 8; n++)
            rdChk(9'h039 + 9'h040 * n[8:0], 8'h41);
        wrReg(9'h039, 8'h00);
        $display("test regs done");
    endtask : tRegs
    // masked bits hidden, then shown but silent
    task tVisible;
        pulse(1);
        rdChk(9'h03A, 8'h00);
        wrReg(9'h039, 8'h80);
        pulse(1);
        waitN(3);
        `CHK(irqOe, 1'b0, "masked bit drove irq")
        rdChk(9'h03F, 8'h00);
        rdChk(9'h03A, 8'h40);
        rdChk(9'h03A, 8'h00);
        $display("test visible done");
    endtask : tVisible
    // open drain, push-pull low, push-pull high
    task tStyle;
        logic [1:0] st [3] = '{2'b00, 2'b01, 2'b11};
        logic [3:0] ex [3] = '{4'b0100, 4'b0111, 4'b1101}; // on out,oe; off out,oe
        wrReg(9'h03C, 8'h00);
        for (int i = 0; i < 3; i++)
        begin
            wrReg(9'h039, {6'h20, st[i]});
            pulse(0);
            waitN(4);
            `CHK({irqOut, irqOe}, ex[i][3:2], "irq active level")
            rdChk(9'h03A, 8'h80);
            waitN(4);
            `CHK({irqOut, irqOe}, ex[i][1:0], "irq idle level")
        end
        wrReg(9'h039, 8'h80);
        $display("test style done");
    endtask : tStyle
    // mode gated events and carrier edges
    task tModes;
        remoteRdy <= 1'b1;
        pulse(2);
        pulse(4);
        rdChk(9'h03A, 8'h00);
        autoM <= 1'b1;
        irqM <= 1'b1;
        remoteRdy <= 1'b0;
        pulse(2);
        pulse(4);
        pulse(3);
        rdChk(9'h03A, 8'h33);
        carrier <= 1'b1;
        waitN(5);
        rdChk(9'h03A, 8'h04);
        carrier <= 1'b0;
        waitN(5);
        rdChk(9'h03A, 8'h04);
        loopM <= 1'b1;
        pulse(7);
        rdChk(9'h03B, 8'h00);
        pulse(5);
        pulse(6);
        rdChk(9'h03B, 8'hC0);
        `CHK(loopRep, 1'b1, "repeat not on after on loop")
        loopM <= 1'b0;
        pulse(7);
        pulse(8);
        rdChk(9'h03B, 8'h41);
        rdChk(9'h03B, 8'h00);
        `CHK(loopRep, 1'b0, "repeat left on outside loop")
        $display("test modes done");
    endtask : tModes
    // lost lock aborts receive and halts transmit
    task tDpll;
        dpllUse <= 1'b1;
        txDpll <= 1'b1;
        locked <= 1'b0;
        waitN(4);
        `CHK({rxAbort, txHalt}, 2'b11, "abort on unlock")
        rdChk(9'h03A, 8'h08);
        locked <= 1'b1;
        waitN(4);
        `CHK(rxAbort, 1'b0, "abort after relock")
        $display("test dpll done");
    endtask : tDpll
    // slave address match, vector clear, rotation
    task tSlave;
        wrReg(9'h03E, 8'h01);
        wrReg(9'h039, 8'hA8);
        pulse(0);
        ackCycle(3'b100);
        rdChk(9'h03A, 8'h80);
        pulse(0);
        ackCycle(3'b101);
        `CHK(highCh, 3'h1, "rotation step")
        rdChk(9'h03A, 8'h00);
        wrReg(9'h03E, 8'h0B);
        wrReg(9'h039, 8'hE8);
        pulse(0);
        ackCycle(3'b101);
        `CHK(highCh, 3'h5, "fixed channel")
        rdChk(9'h03F, 8'h05);
        $display("test slave done");
    endtask : tSlave
    // daisy chain enable in and out
    task tDaisy;
        wrReg(9'h039, 8'h84);
        rdChk(9'h03A, 8'h00);
        pulse(0);
        waitN(4);
        `CHK({ch0Oe, ch0Out}, 2'b10, "chain out blocked")
        rdChk(9'h03F, 8'h0D);
        ackCycle(3'b000);
        rdChk(9'h03A, 8'h80);
        pulse(0);
        ackCycle(3'b010);
        rdChk(9'h03A, 8'h00);
        $display("test daisy done");
    endtask : tDaisy
    // main sequence
    initial
    begin
        waitN(5);
        arst_n <= 1'b1;
        tRegs();
        tVisible();
        tStyle();
        tModes();
        tDpll();
        tSlave();
        tDaisy();
        finish_test();
    end
endmodule : serial_channel_irq_status_bench
